// ---- include/gog_pkg.sv ----
// constants and types shared by the gain, offset and output guard block
package gog_pkg;
	// datapath widths
	localparam int DATA_W = 16;
	localparam int GAIN_W = 6;
	localparam int GAIN_FRAC = 5;
	localparam int STEP_SHIFT = 1;
	localparam int CHANNELS = 2;
	localparam int CH_I = 0;
	localparam int CH_Q = 1;

	// gain steps every four converter cycles
	localparam int STEP_CYCLES = 4;

	// register offsets
	localparam logic [7:0] ADDR_Q_OFS_LO = 8'h3d;
	localparam logic [7:0] ADDR_Q_OFS_HI = 8'h3e;
	localparam logic [7:0] ADDR_I_GAIN = 8'h3f;
	localparam logic [7:0] ADDR_Q_GAIN = 8'h40;
	localparam logic [7:0] ADDR_UP_STEP = 8'h41;
	localparam logic [7:0] ADDR_DN_STEP = 8'h42;
	localparam logic [7:0] ADDR_TX_CTL = 8'h43;
	localparam logic [7:0] ADDR_PROT_CTL = 8'h44;

	// values after reset
	localparam logic [7:0] RST_Q_OFS_LO = 8'h00;
	localparam logic [7:0] RST_Q_OFS_HI = 8'h00;
	localparam logic [5:0] RST_GAIN = 6'h20;
	localparam logic [5:0] RST_UP_STEP = 6'h01;
	localparam logic [5:0] RST_DN_STEP = 6'h01;
	localparam logic [2:0] RST_TX_CTL = 3'h7;
	localparam logic [7:0] RST_PROT_CTL = 8'h8f;
	localparam logic [7:0] PROT_MASK = 8'h8f;

	// field positions
	localparam int DN_STATUS_BIT = 7;
	localparam int DN_RESTORE_BIT = 6;
	localparam int TX_RAMP_BIT = 2;
	localparam int TX_SLEEP_BIT = 1;
	localparam int TX_PD_BIT = 0;
	localparam int PROT_MASTER_BIT = 7;
	localparam int PROT_WARN_BIT = 3;
	localparam int PROT_OVER_BIT = 2;
	localparam int PROT_ERR_BIT = 0;

	// output state, gray along on -> gated -> tripped
	typedef enum logic [1:0] {
		ST_ON = 2'b00,
		ST_TX_OFF = 2'b01,
		ST_AUTO_OFF = 2'b11
	} out_state_t;
endpackage

// ---- include/ramp_ctl_if.sv ----
// shared ramp control from the guard to the per-channel gain ramps
`timescale 1ns/1ns
interface ramp_ctl_if #(parameter int GAIN_W = 6);
	logic tick;
	logic want_on;
	logic ramp_en;
	logic [GAIN_W-1:0] up_step;
	logic [GAIN_W-1:0] dn_step;
	modport ctl(output tick, want_on, ramp_en, up_step, dn_step);
	modport ramp(input tick, want_on, ramp_en, up_step, dn_step);
endinterface

// ---- verilog/gain_ramp.sv ----
// working gain of one channel, ramped toward target or zero
`timescale 1ns/1ns
module gain_ramp #(
	parameter int GAIN_W = gog_pkg::GAIN_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// shared ramp control
	ramp_ctl_if.ramp ctl,
	// programmed gain and working gain
	input wire logic [GAIN_W-1:0] i_target,
	output logic [GAIN_W-1:0] o_gain,
	output logic o_at_zero
);
	import gog_pkg::*;

	localparam int WIDE = GAIN_W + 2;

	logic [GAIN_W-1:0] gain_r;
	logic [GAIN_W-1:0] gain_nxt;
	logic [WIDE-1:0] cur_w;
	logic [WIDE-1:0] tgt_w;
	logic [WIDE-1:0] up_amt;
	logic [WIDE-1:0] dn_amt;
	logic [WIDE-1:0] sum_up;
	logic [WIDE-1:0] diff_dn;

	assign cur_w = WIDE'(gain_r);
	assign tgt_w = WIDE'(i_target);
	// steps count in sixteenths, gain in thirty-seconds
	assign up_amt = WIDE'(ctl.up_step) << STEP_SHIFT;
	assign dn_amt = WIDE'(ctl.dn_step) << STEP_SHIFT;
	assign sum_up = cur_w + up_amt;
	assign diff_dn = cur_w - dn_amt;

	always_comb begin
		gain_nxt = gain_r;
		if (!ctl.ramp_en) begin
			gain_nxt = ctl.want_on ? i_target : '0;
		end else if (ctl.want_on) begin
			if (cur_w > tgt_w) begin
				gain_nxt = i_target;
			end else if (ctl.tick) begin
				gain_nxt = (sum_up >= tgt_w) ? i_target : sum_up[GAIN_W-1:0];
			end
		end else if (ctl.tick) begin
			gain_nxt = (cur_w <= dn_amt) ? '0 : diff_dn[GAIN_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			gain_r <= '0;
		end else begin
			gain_r <= gain_nxt;
		end
	end

	assign o_gain = gain_r;
	assign o_at_zero = (gain_r == '0);

	property p_up_hold;
		@(posedge i_clk) disable iff (i_rst)
		ctl.ramp_en && ctl.want_on && !ctl.tick && (cur_w <= tgt_w) |=> gain_r == $past(gain_r);
	endproperty
	a_up_hold: assert property (p_up_hold) else $error("gain moved between steps");

	property p_up_step;
		@(posedge i_clk) disable iff (i_rst)
		ctl.ramp_en && ctl.want_on && ctl.tick && (sum_up < tgt_w) |=> WIDE'(gain_r) == $past(sum_up);
	endproperty
	a_up_step: assert property (p_up_step) else $error("up step amount wrong");

	property p_down_step;
		@(posedge i_clk) disable iff (i_rst)
		ctl.ramp_en && !ctl.want_on && ctl.tick && (gain_r != '0) |=> gain_r < $past(gain_r);
	endproperty
	a_down_step: assert property (p_down_step) else $error("down ramp did not decrease");

	property p_snap;
		@(posedge i_clk) disable iff (i_rst)
		!ctl.ramp_en |=> gain_r == ($past(ctl.want_on) ? $past(i_target) : '0);
	endproperty
	a_snap: assert property (p_snap) else $error("gain did not snap without ramping");
endmodule

// ---- verilog/sample_scale.sv ----
// one channel: gain multiply, dc offset add, saturate, register
`timescale 1ns/1ns
module sample_scale #(
	parameter int DATA_W = gog_pkg::DATA_W,
	parameter int GAIN_W = gog_pkg::GAIN_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// input sample, gain and offset
	input wire logic i_valid,
	input wire logic signed [DATA_W-1:0] i_sample,
	input wire logic [GAIN_W-1:0] i_gain,
	input wire logic signed [DATA_W-1:0] i_offset,
	// scaled sample
	output logic o_valid,
	output logic signed [DATA_W-1:0] o_sample
);
	import gog_pkg::*;

	localparam int PROD_W = DATA_W + GAIN_W + 1;
	localparam int ACC_W = PROD_W + 1;
	localparam logic signed [ACC_W-1:0] SAT_HI = ACC_W'((2 ** (DATA_W - 1)) - 1);
	localparam logic signed [ACC_W-1:0] SAT_LO = ACC_W'(-(2 ** (DATA_W - 1)));

	logic signed [PROD_W-1:0] prod;
	logic signed [ACC_W-1:0] acc;
	logic signed [DATA_W-1:0] sat;

	always_comb begin
		prod = PROD_W'(i_sample) * PROD_W'($signed({1'b0, i_gain}));
		acc = ACC_W'(prod >>> GAIN_FRAC) + ACC_W'(i_offset);
		if (acc > SAT_HI) begin
			sat = SAT_HI[DATA_W-1:0];
		end else if (acc < SAT_LO) begin
			sat = SAT_LO[DATA_W-1:0];
		end else begin
			sat = acc[DATA_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_valid <= 1'b0;
			o_sample <= '0;
		end else begin
			o_valid <= i_valid;
			if (i_valid) begin
				o_sample <= sat;
			end
		end
	end

	property p_unity;
		@(posedge i_clk) disable iff (i_rst)
		i_valid && (i_gain == RST_GAIN) && (i_offset == '0) |=> o_sample == $past(i_sample);
	endproperty
	a_unity: assert property (p_unity) else $error("unity gain altered sample");
endmodule

// ---- verilog/gain_offset_output_guard.sv ----
// gain, q offset, gain ramping and automatic output shutdown for a dual converter
//
// Summary of operation
// - add 16-bit dc offset to Q samples
// - I gain six bits, unity at 0x20
// - Q gain six bits, unity at 0x20
// - ramp up every four cycles to target
// - ramp down every four cycles to zero
// - down-step bit 7 reads output off
// - down-step bit 6 write restores output
// - ramp enable makes transmit gate ramp
// - sleep while transmit gate low if enabled
// - power down while gate low if enabled
// - master bit enables all protection bits
// - queue warning cuts output when enabled
// - over-power cuts output when enabled
// - queue error or warning cuts output
`timescale 1ns/1ns
module gain_offset_output_guard (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// transmit gate and protection events
	input wire logic i_transmit_gate_pin,
	input wire logic i_fifo_warning,
	input wire logic i_fifo_error,
	input wire logic i_over_power,
	// samples from the interpolation path
	input wire logic i_sample_valid,
	input wire logic signed [gog_pkg::DATA_W-1:0] i_i_sample,
	input wire logic signed [gog_pkg::DATA_W-1:0] i_q_sample,
	// samples to the converters
	output logic o_sample_valid,
	output logic signed [gog_pkg::DATA_W-1:0] o_i_sample,
	output logic signed [gog_pkg::DATA_W-1:0] o_q_sample,
	// output and power status
	output logic o_output_off,
	output logic o_output_muted,
	output logic o_sleep,
	output logic o_powerdown
);
	import gog_pkg::*;

	localparam int TICK_W = $clog2(STEP_CYCLES);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STEP_CYCLES - 1);

	// register storage
	logic [7:0] q_offset_low_r;
	logic [7:0] q_offset_high_r;
	logic [GAIN_W-1:0] i_gain_trim_r;
	logic [GAIN_W-1:0] q_gain_trim_r;
	logic [GAIN_W-1:0] ramp_up_step_r;
	logic [GAIN_W-1:0] ramp_down_step_r;
	logic [2:0] tx_gate_control_r;
	logic [7:0] output_protect_control_r;

	// control state
	out_state_t state_r;
	out_state_t state_nxt;
	logic tx_prev_r;
	logic [TICK_W-1:0] tick_cnt_r;
	logic tick;
	logic tx_rise;
	logic restore;
	logic trip;
	logic wr_dn;
	logic [7:0] rd_mux;

	// per-channel wiring
	logic [GAIN_W-1:0] target [CHANNELS];
	logic [GAIN_W-1:0] work_gain [CHANNELS];
	logic [CHANNELS-1:0] at_zero;
	logic signed [DATA_W-1:0] in_smp [CHANNELS];
	logic signed [DATA_W-1:0] ofs [CHANNELS];
	logic signed [DATA_W-1:0] out_smp [CHANNELS];
	logic [CHANNELS-1:0] out_valid;

	ramp_ctl_if #(.GAIN_W(GAIN_W)) ramp_bus ();

	// register writes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			q_offset_low_r <= RST_Q_OFS_LO;
			q_offset_high_r <= RST_Q_OFS_HI;
		end else if (i_reg_wr && i_reg_addr == ADDR_Q_OFS_LO) begin
			q_offset_low_r <= i_reg_wdata;
		end else if (i_reg_wr && i_reg_addr == ADDR_Q_OFS_HI) begin
			q_offset_high_r <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			i_gain_trim_r <= RST_GAIN;
			q_gain_trim_r <= RST_GAIN;
		end else if (i_reg_wr && i_reg_addr == ADDR_I_GAIN) begin
			i_gain_trim_r <= i_reg_wdata[GAIN_W-1:0];
		end else if (i_reg_wr && i_reg_addr == ADDR_Q_GAIN) begin
			q_gain_trim_r <= i_reg_wdata[GAIN_W-1:0];
		end
	end

	assign wr_dn = i_reg_wr && (i_reg_addr == ADDR_DN_STEP);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ramp_up_step_r <= RST_UP_STEP;
			ramp_down_step_r <= RST_DN_STEP;
		end else if (i_reg_wr && i_reg_addr == ADDR_UP_STEP) begin
			ramp_up_step_r <= i_reg_wdata[GAIN_W-1:0];
		end else if (wr_dn) begin
			ramp_down_step_r <= i_reg_wdata[GAIN_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_gate_control_r <= RST_TX_CTL;
			output_protect_control_r <= RST_PROT_CTL;
		end else if (i_reg_wr && i_reg_addr == ADDR_TX_CTL) begin
			tx_gate_control_r <= i_reg_wdata[2:0];
		end else if (i_reg_wr && i_reg_addr == ADDR_PROT_CTL) begin
			output_protect_control_r <= i_reg_wdata & PROT_MASK;
		end
	end

	// restore is a write strobe only, so the bit always reads back zero
	assign restore = wr_dn && i_reg_wdata[DN_RESTORE_BIT];

	// register reads
	always_comb begin
		rd_mux = 8'h00;
		unique case (i_reg_addr)
			ADDR_Q_OFS_LO: rd_mux = q_offset_low_r;
			ADDR_Q_OFS_HI: rd_mux = q_offset_high_r;
			ADDR_I_GAIN: rd_mux = 8'(i_gain_trim_r);
			ADDR_Q_GAIN: rd_mux = 8'(q_gain_trim_r);
			ADDR_UP_STEP: rd_mux = 8'(ramp_up_step_r);
			ADDR_DN_STEP: rd_mux = {state_r != ST_ON, 1'b0, ramp_down_step_r};
			ADDR_TX_CTL: rd_mux = 8'(tx_gate_control_r);
			ADDR_PROT_CTL: rd_mux = output_protect_control_r;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= rd_mux;
			end
		end
	end

	// step tick every four cycles
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
		end
	end

	assign tick = (tick_cnt_r == TICK_LAST);

	// transmit gate edge
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_prev_r <= 1'b0;
		end else begin
			tx_prev_r <= i_transmit_gate_pin;
		end
	end

	assign tx_rise = i_transmit_gate_pin && !tx_prev_r;

	// protection trip, all gated by the master bit
	assign trip = output_protect_control_r[PROT_MASTER_BIT] && (
		(output_protect_control_r[PROT_WARN_BIT] && i_fifo_warning) ||
		(output_protect_control_r[PROT_OVER_BIT] && i_over_power) ||
		(output_protect_control_r[PROT_ERR_BIT] && (i_fifo_error || i_fifo_warning)));

	// output state, trip beats restore in the same cycle
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_ON: begin
				if (trip) begin
					state_nxt = ST_AUTO_OFF;
				end else if (!i_transmit_gate_pin) begin
					state_nxt = ST_TX_OFF;
				end
			end
			ST_TX_OFF: begin
				if (trip) begin
					state_nxt = ST_AUTO_OFF;
				end else if (i_transmit_gate_pin || restore) begin
					state_nxt = i_transmit_gate_pin ? ST_ON : ST_TX_OFF;
				end
			end
			ST_AUTO_OFF: begin
				if (!trip && (restore || tx_rise)) begin
					state_nxt = ST_ON;
				end
			end
			default: state_nxt = ST_AUTO_OFF;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r <= ST_TX_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// sleep and power-down follow the gate pin
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_sleep <= 1'b0;
			o_powerdown <= 1'b0;
		end else begin
			o_sleep <= tx_gate_control_r[TX_SLEEP_BIT] && !i_transmit_gate_pin;
			o_powerdown <= tx_gate_control_r[TX_PD_BIT] && !i_transmit_gate_pin;
		end
	end

	// shared ramp control, shutdowns reuse the down ramp
	assign ramp_bus.tick = tick;
	assign ramp_bus.want_on = (state_r == ST_ON);
	assign ramp_bus.ramp_en = tx_gate_control_r[TX_RAMP_BIT];
	assign ramp_bus.up_step = ramp_up_step_r;
	assign ramp_bus.dn_step = ramp_down_step_r;

	assign target[CH_I] = i_gain_trim_r;
	assign target[CH_Q] = q_gain_trim_r;
	assign in_smp[CH_I] = i_i_sample;
	assign in_smp[CH_Q] = i_q_sample;
	assign ofs[CH_I] = '0;
	assign ofs[CH_Q] = {q_offset_high_r, q_offset_low_r};

	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
		gain_ramp #(.GAIN_W(GAIN_W)) u_ramp (
			.i_clk(i_clk),
			.i_rst(i_rst),
			.ctl(ramp_bus),
			.i_target(target[ch]),
			.o_gain(work_gain[ch]),
			.o_at_zero(at_zero[ch])
		);
		sample_scale #(.DATA_W(DATA_W), .GAIN_W(GAIN_W)) u_scale (
			.i_clk(i_clk),
			.i_rst(i_rst),
			.i_valid(i_sample_valid),
			.i_sample(in_smp[ch]),
			.i_gain(work_gain[ch]),
			.i_offset(ofs[ch]),
			.o_valid(out_valid[ch]),
			.o_sample(out_smp[ch])
		);
	end

	assign o_sample_valid = &out_valid;
	assign o_i_sample = out_smp[CH_I];
	assign o_q_sample = out_smp[CH_Q];
	assign o_output_off = (state_r != ST_ON);
	assign o_output_muted = &at_zero;

	property p_tick_period;
		@(posedge i_clk) disable iff (i_rst)
		tick |=> !tick [*3] ##1 tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("step tick not every four cycles");

	property p_status_read;
		@(posedge i_clk) disable iff (i_rst)
		i_reg_rd && (i_reg_addr == ADDR_DN_STEP) |=> o_reg_rdata[DN_STATUS_BIT] == $past(state_r != ST_ON)
			&& !o_reg_rdata[DN_RESTORE_BIT];
	endproperty
	a_status_read: assert property (p_status_read) else $error("output status read wrong");

	property p_restore;
		@(posedge i_clk) disable iff (i_rst)
		(state_r == ST_AUTO_OFF) && restore && !trip |=> state_r == ST_ON;
	endproperty
	a_restore: assert property (p_restore) else $error("restore did not turn output on");

	property p_sleep;
		@(posedge i_clk) disable iff (i_rst)
		tx_gate_control_r[TX_SLEEP_BIT] && !i_transmit_gate_pin |=> o_sleep;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered with gate low");

	property p_powerdown;
		@(posedge i_clk) disable iff (i_rst)
		!tx_gate_control_r[TX_PD_BIT] || i_transmit_gate_pin |=> !o_powerdown;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("power down without cause");

	property p_master;
		@(posedge i_clk) disable iff (i_rst)
		!output_protect_control_r[PROT_MASTER_BIT] && (state_r == ST_ON) && i_transmit_gate_pin
			|=> state_r == ST_ON;
	endproperty
	a_master: assert property (p_master) else $error("protection acted with master off");

	property p_warn_cut;
		@(posedge i_clk) disable iff (i_rst)
		output_protect_control_r[PROT_MASTER_BIT] && output_protect_control_r[PROT_WARN_BIT] && i_fifo_warning
			|=> state_r == ST_AUTO_OFF;
	endproperty
	a_warn_cut: assert property (p_warn_cut) else $error("warning did not cut output");

	property p_over_cut;
		@(posedge i_clk) disable iff (i_rst)
		output_protect_control_r[PROT_MASTER_BIT] && output_protect_control_r[PROT_OVER_BIT] && i_over_power
			|=> state_r == ST_AUTO_OFF;
	endproperty
	a_over_cut: assert property (p_over_cut) else $error("over-power did not cut output");

	property p_err_cut;
		@(posedge i_clk) disable iff (i_rst)
		output_protect_control_r[PROT_MASTER_BIT] && output_protect_control_r[PROT_ERR_BIT] && i_fifo_error
			|=> state_r == ST_AUTO_OFF;
	endproperty
	a_err_cut: assert property (p_err_cut) else $error("queue error did not cut output");

	property p_hold_off;
		@(posedge i_clk) disable iff (i_rst)
		(state_r == ST_AUTO_OFF) && !restore && !tx_rise |=> state_r == ST_AUTO_OFF;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("output left cutoff on its own");
endmodule

// ---- dv/sample_source.sv ----
// upstream sample source model: constant level or random samples
`timescale 1ns/1ns
module sample_source (
	// clock and mode
	input wire logic i_clk,
	input wire logic i_rand,
	input wire logic [15:0] i_level,
	// samples toward the block
	output logic o_valid,
	output logic [15:0] o_i,
	output logic [15:0] o_q
);
	integer seed = 76;
	// new sample just after each edge
	initial begin
		o_valid = 1'b0;
		o_i = 16'h0000;
		o_q = 16'h0000;
		forever begin
			@(posedge i_clk);
			#1;
			o_valid = i_rand ? 1'($random(seed)) : 1'b1;
			o_i = i_rand ? 16'($random(seed)) : i_level;
			o_q = i_rand ? 16'($random(seed)) : i_level;
		end
	end
endmodule

// ---- dv/tb_gain_offset_output_guard.sv ----
// self-checking bench for the gain, offset and output guard block
`timescale 1ns/1ns
module tb_gain_offset_output_guard;
	import gog_pkg::*;
	typedef struct {logic [15:0] ei; logic [15:0] eq; bit chk;} exp_t;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic gate = 1'b0;
	logic warn = 1'b0;
	logic err = 1'b0;
	logic over = 1'b0;
	logic src_rand = 1'b0;
	logic [15:0] src_level = 16'h1000;
	logic [7:0] reg_rdata;
	logic reg_rvalid, s_valid, o_valid, out_off, muted, sleep, pd;
	logic [15:0] s_i, s_q, o_i, o_q, ofsb;
	int fails = 0;
	int tests_run = 0;
	int seed = 76;
	int gi = 0;
	int gq = 0;
	int ofs = 0;
	bit chk = 0;
	logic v_prev = 1'b0;
	exp_t e;
	exp_t q_exp[$];
	logic [7:0] rst_val [9] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h01, 8'h81, 8'h07, 8'h8f, 8'h00};
	logic [7:0] prot [7] = '{8'h88, 8'h81, 8'h81, 8'h84, 8'h0f, 8'h8b, 8'h84};
	logic [2:0] cause [7] = '{3'b100, 3'b100, 3'b010, 3'b001, 3'b111, 3'b001, 3'b110};
	logic trip [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

	gain_offset_output_guard DUT (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
		.i_transmit_gate_pin(gate), .i_fifo_warning(warn), .i_fifo_error(err), .i_over_power(over),
		.i_sample_valid(s_valid), .i_i_sample(s_i), .i_q_sample(s_q), .o_sample_valid(o_valid),
		.o_i_sample(o_i), .o_q_sample(o_q), .o_output_off(out_off), .o_output_muted(muted),
		.o_sleep(sleep), .o_powerdown(pd));
	sample_source src (.i_clk(i_clk), .i_rand(src_rand), .i_level(src_level), .o_valid(s_valid),
		.o_i(s_i), .o_q(s_q));

	initial begin
		forever #5 i_clk = ~i_clk;
	end

	function automatic logic [15:0] sat(input int v);
		return v > 32767 ? 16'h7fff : (v < -32768 ? 16'h8000 : 16'(v));
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// reference model of the sample path, one cycle behind
	always @(posedge i_clk) begin
		if (i_rst) begin
			q_exp.delete();
			v_prev = 1'b0;
		end else begin
			check(16'(o_valid), 16'(v_prev));
			v_prev = s_valid;
			if (o_valid === 1'b1 && q_exp.size() > 0) begin
				e = q_exp.pop_front();
				if (e.chk) begin
					check(o_i, e.ei);
					check(o_q, e.eq);
				end
			end
			if (s_valid === 1'b1) begin
				e.ei = sat((int'($signed(s_i)) * gi) >>> 5);
				e.eq = sat(((int'($signed(s_q)) * gq) >>> 5) + ofs);
				e.chk = chk;
				q_exp.push_back(e);
			end
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		cyc(1);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		cyc(1);
		reg_rd = 1'b1;
		reg_addr = a;
		cyc(1);
		reg_rd = 1'b0;
		check(16'(reg_rvalid), 16'h0001);
		check(16'(reg_rdata), 16'(exp));
	endtask

	// counts output steps of a constant sample and their spacing
	task automatic ramp(input int step, input int n);
		int gap;
		int seen;
		logic [15:0] prev;
		prev = o_i;
		gap = 0;
		seen = 0;
		repeat (300) begin
			cyc(1);
			gap++;
			if (o_i !== prev) begin
				check(16'(o_i - prev), 16'(step));
				if (seen > 0) check(16'(gap), 16'(STEP_CYCLES));
				prev = o_i;
				gap = 0;
				seen++;
			end
		end
		check(16'(seen), 16'(n));
	endtask

	task automatic done(input string name);
		$display("test %s finished, %0d compares, %0d mismatches", name, tests_run, fails);
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		fails++;
		stop_test();
	end

	initial begin
		cyc(8);
		i_rst = 1'b0;
		for (int k = 0; k < 9; k++) rd(8'h3d + 8'(k), rst_val[k]);
		rd(8'h00, 8'h00);
		wr(8'h3f, 8'hff);
		rd(8'h3f, 8'h3f);
		wr(8'h3f, 8'h20);
		wr(8'h44, 8'hff);
		rd(8'h44, 8'h8f);
		wr(8'h44, 8'h8f);
		wr(8'h42, 8'hff);
		rd(8'h42, 8'hbf);
		check(16'(out_off), 16'h0001);
		wr(8'h42, 8'h01);
		wr(8'h45, 8'hff);
		rd(8'h45, 8'h00);
		done("registers");
		gate = 1'b1;
		ramp(256, 16);
		check(16'(out_off), 16'h0000);
		done("ramp up");
		repeat (3) begin
			gi = 2 + {$random(seed)} % 62;
			gq = 2 + {$random(seed)} % 62;
			ofsb = 16'($random(seed));
			ofs = int'($signed(ofsb));
			wr(8'h3f, 8'(gi));
			wr(8'h40, 8'(gq));
			wr(8'h3d, ofsb[7:0]);
			wr(8'h3e, ofsb[15:8]);
			rd(8'h3d, ofsb[7:0]);
			rd(8'h3e, ofsb[15:8]);
			cyc(150);
			src_rand = 1'b1;
			chk = 1;
			cyc(200);
			chk = 0;
			src_rand = 1'b0;
		end
		done("gain and offset");
		wr(8'h3f, 8'h20);
		cyc(150);
		for (int k = 0; k < 7; k++) begin
			wr(8'h44, prot[k]);
			{warn, err, over} = cause[k];
			cyc(1);
			{warn, err, over} = 3'b000;
			if (k == 0) ramp(-256, 16);
			if (k == 0) check(16'(muted), 16'h0001);
			cyc(3);
			check(16'(out_off), 16'(trip[k]));
			rd(8'h42, {trip[k], 7'h01});
			wr(8'h42, 8'h41);
			cyc(2);
			check(16'(out_off), 16'h0000);
			rd(8'h42, 8'h01);
			cyc(150);
		end
		done("protection");
		for (int t = 0; t < 8; t++) begin
			wr(8'h43, 8'(t));
			gate = 1'b0;
			cyc(3);
			check(16'(sleep), 16'(t[1]));
			check(16'(pd), 16'(t[0]));
			check(16'(out_off), 16'h0001);
			if (t[2] == 1'b0) check(16'(muted), 16'h0001);
			else check(16'(muted), 16'h0000);
			gate = 1'b1;
			cyc(3);
			check(16'({sleep, pd}), 16'h0000);
			cyc(80);
		end
		done("transmit gate");
		stop_test();
	end
endmodule
